// *** rtl/asr_receiver.sv ***
// receive side of an asynchronous serial interface with sample-tick data recovery
// How it works
// [R1] eight or nine data bits, ninth bit high
// [R2] full frame loads data, sets full flag
// [R3] full flag with enable raises interrupt
// [R4] sixteen sample ticks per bit time
// [R5] realign after start and one-to-zero data
// [R6] start search: three highs then low
// [R7] verify at 3,5,7; one high noise
// [R8] failed verification restarts the search
// [R9] data bit is majority of 8,9,10
// [R10] start bit mid samples only flag noise
// [R11] stop majority zero sets framing error
// [R12] rejected start never sets noise flag
// [R13] framing error set with full flag
// [R14] resync on falling edges during data bits, after a one
// [R15] release transmit pin when idle, disabled
// [R16] software queues idle by toggling enable; not done here, tx_enable_bit only feeds tx_pin_oe
// [R17] break: all zero data and stop
// [R18] break clears the receive data
// [R19] synchronise input, divider gives tick enable
`default_nettype none
module asr_receiver (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// serial line from the remote transmitter
	input  wire logic                     rx_pin,
	// configuration
	input  wire logic                     char_nine_bits,
	input  wire logic                     rx_irq_enable,
	input  wire logic [asr_pkg::DIV_W-1:0] baud_div,
	// software side
	input  wire logic                     rx_read,
	output var  asr_pkg::asr_data_t       rx_data,
	output var  asr_pkg::asr_status_t     rx_status,
	output wire logic                     rx_irq,
	// transmit pin ownership
	input  wire logic                     tx_enable_bit,
	input  wire logic                     tx_in_progress,
	output wire logic                     tx_pin_oe
);
	import asr_pkg::*;

	// ---------------------------------------------
	// reset release
	// ---------------------------------------------
	logic rst_meta_r;                                   // first release stage
	logic rst_sync_n;                                   // released copy used everywhere

	// async assert, clocked release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// ---------------------------------------------
	// line synchroniser and tick divider
	// ---------------------------------------------
	logic             rx_s1_r, rx_s2_r, rx_s3_r;        // three-stage pin capture
	logic             rx_lvl_r, rx_lvl_nxt;             // filtered line level
	logic [DIV_W-1:0] div_cnt_r, div_cnt_nxt;           // counts down to the next tick
	logic             rt_tick;                          // one sample tick pulse

	// [R19] level moves only when stages two and three agree
	always_comb begin
		rx_lvl_nxt  = (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_lvl_r;
		// zero divisor parks the divider
		if (baud_div == DIV_OFF) begin
			div_cnt_nxt = DIV_OFF;
		end else if (div_cnt_r <= DIV_ONE) begin
			div_cnt_nxt = baud_div;
		end else begin
			div_cnt_nxt = div_cnt_r - DIV_ONE;
		end
	end
	// [R4] tick enable at sixteen times baud
	assign rt_tick = (baud_div != DIV_OFF) && (div_cnt_r <= DIV_ONE);

	// idle line is high, so the capture starts high
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_s1_r   <= 1'b1;
			rx_s2_r   <= 1'b1;
			rx_s3_r   <= 1'b1;
			rx_lvl_r  <= 1'b1;
			div_cnt_r <= DIV_OFF;
		end else begin
			rx_s1_r   <= rx_pin;
			rx_s2_r   <= rx_s1_r;
			rx_s3_r   <= rx_s2_r;
			rx_lvl_r  <= rx_lvl_nxt;
			div_cnt_r <= div_cnt_nxt;
		end
	end

	// ---------------------------------------------
	// data recovery
	// ---------------------------------------------
	asr_state_t       state_r, state_nxt;               // recovery phase
	logic [RT_W-1:0]  rt_r, rt_nxt;                     // index of the sample taken now
	logic [2:0]       hist_r, hist_nxt;                 // last three samples
	logic [1:0]       votes_r, votes_nxt;               // high verify samples
	logic             m8_r, m8_nxt, m9_r, m9_nxt;       // held majority samples
	logic [3:0]       idx_r, idx_nxt;                   // data bit index
	logic [8:0]       shreg_r, shreg_nxt;               // receive shift register
	logic             pend_r, pend_nxt;                 // noise seen in this frame
	logic             one_r, one_nxt;                   // last data bit was one
	asr_data_t        data_r, data_nxt;                 // receive data buffer
	asr_status_t      stat_r, stat_nxt;                 // sticky flags
	logic             smp, edge_seen, maj, dis;         // sample helpers
	logic             frame_done, start_reject, brk;    // event pulses
	logic [1:0]       vote_now;                         // votes including this tick
	logic [3:0]       last_idx;                         // last data index for the length

	always_comb begin
		smp          = rx_lvl_r;
		edge_seen    = (hist_r == HIST_IDLE) && !smp;
		maj          = (m8_r & m9_r) | (m8_r & smp) | (m9_r & smp);
		dis          = !((m8_r == m9_r) && (m9_r == smp));
		// [R1] length picks the last data index
		last_idx     = char_nine_bits ? IDX_W9 : IDX_W8;
		vote_now     = votes_r + {1'b0, smp};
		state_nxt    = state_r;
		rt_nxt       = rt_r;
		hist_nxt     = hist_r;
		votes_nxt    = votes_r;
		m8_nxt       = m8_r;
		m9_nxt       = m9_r;
		idx_nxt      = idx_r;
		shreg_nxt    = shreg_r;
		pend_nxt     = pend_r;
		one_nxt      = one_r;
		data_nxt     = data_r;
		stat_nxt     = stat_r;
		frame_done   = 1'b0;
		start_reject = 1'b0;
		brk          = 1'b0;
		// software read clears first, so a same-cycle set wins
		if (rx_read) begin
			stat_nxt = '0;
		end
		if (rt_tick) begin
			hist_nxt = {hist_r[1:0], smp};
			rt_nxt   = (rt_r == RT_LAST) ? RT_FIRST : rt_r + RT_FIRST;
			if (rt_r == RT_M8) begin
				m8_nxt = smp;
			end
			if (rt_r == RT_M9) begin
				m9_nxt = smp;
			end
			unique case (state_r)
				ST_SEARCH: begin
					rt_nxt = RT_IDLE;
					// [R6] falling edge after three highs
					if (edge_seen) begin
						state_nxt = ST_START;
						rt_nxt    = RT_SECOND;
						votes_nxt = 2'h0;
						pend_nxt  = 1'b0;
						shreg_nxt = '0;
					end
				end
				ST_START: begin
					if (rt_r == RT_V3 || rt_r == RT_V5 || rt_r == RT_V7) begin
						votes_nxt = vote_now;
					end
					// [R7] two or more highs reject the start
					if (rt_r == RT_V7 && vote_now >= VOTE_REJ) begin
						// [R8] reset tick count and search again
						// [R12] pending noise stays clear on a rejected start
						state_nxt    = ST_SEARCH;
						rt_nxt       = RT_IDLE;
						start_reject = 1'b1;
					end else if (rt_r == RT_V7 && vote_now != 2'h0) begin
						pend_nxt = 1'b1;
					end
					// [R10] high mid samples only mark noise
					if ((rt_r == RT_M8 || rt_r == RT_M9 || rt_r == RT_M10) && smp) begin
						pend_nxt = 1'b1;
					end
					// [R5] first data bit aligned to the start edge
					if (rt_r == RT_LAST) begin
						state_nxt = ST_DATA;
						idx_nxt   = 4'h0;
						one_nxt   = 1'b0;
					end
				end
				ST_DATA: begin
					// [R9] majority decides the bit, disagreement is noise
					if (rt_r == RT_M10) begin
						shreg_nxt[idx_r] = maj;
						one_nxt          = maj;
						pend_nxt         = pend_r | dis;
					end
					if (rt_r == RT_LAST) begin
						state_nxt = (idx_r == last_idx) ? ST_STOP : ST_DATA;
						idx_nxt   = idx_r + 4'h1;
					end
					// [R14] edge after a one realigns the tick count
					if (edge_seen && one_r && rt_r > RT_M10) begin
						state_nxt = (idx_r == last_idx) ? ST_STOP : ST_DATA;
						idx_nxt   = idx_r + 4'h1;
						rt_nxt    = RT_SECOND;
						one_nxt   = 1'b0;
					end else if (edge_seen && one_r && rt_r < RT_M8) begin
						// [R5] late edge starts the current bit over
						rt_nxt  = RT_SECOND;
						one_nxt = 1'b0;
					end
				end
				ST_STOP: begin
					if (rt_r == RT_M10) begin
						frame_done = 1'b1;
						// [R17] zero data and zero stop is a break
						brk        = (shreg_r == '0) && !maj;
						// [R2] load buffer and flag it full
						stat_nxt.rx_full_flag = 1'b1;
						// [R11] stop majority zero is a framing error
						// [R13] framing error lands with the full flag
						stat_nxt.framing_error_flag = stat_nxt.framing_error_flag | !maj;
						stat_nxt.noise_flag = stat_nxt.noise_flag | pend_r | dis;
						// [R18] a break leaves the buffer cleared
						if (brk) begin
							data_nxt = '0;
						end else begin
							data_nxt.rx_low       = shreg_r[7:0];
							data_nxt.rx_ninth_bit = char_nine_bits & shreg_r[8];
						end
						state_nxt = ST_SEARCH;
						rt_nxt    = RT_IDLE;
					end
				end
			endcase
		end
	end

	// registers of the recovery path
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r <= ST_SEARCH;
			rt_r    <= RT_IDLE;
			hist_r  <= 3'h0;
			votes_r <= 2'h0;
			m8_r    <= 1'b0;
			m9_r    <= 1'b0;
			idx_r   <= 4'h0;
			shreg_r <= 9'h000;
			pend_r  <= 1'b0;
			one_r   <= 1'b0;
			data_r  <= '0;
			stat_r  <= '0;
		end else begin
			state_r <= state_nxt;
			rt_r    <= rt_nxt;
			hist_r  <= hist_nxt;
			votes_r <= votes_nxt;
			m8_r    <= m8_nxt;
			m9_r    <= m9_nxt;
			idx_r   <= idx_nxt;
			shreg_r <= shreg_nxt;
			pend_r  <= pend_nxt;
			one_r   <= one_nxt;
			data_r  <= data_nxt;
			stat_r  <= stat_nxt;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign rx_data   = data_r;
	assign rx_status = stat_r;
	// [R3] enabled full flag requests an interrupt
	assign rx_irq    = rx_irq_enable & stat_r.rx_full_flag;
	// [R15] pin released when disabled and nothing shifting
	assign tx_pin_oe = tx_enable_bit | tx_in_progress;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n);

	irq_gate_a: assert property (rx_irq == (rx_irq_enable && stat_r.rx_full_flag)) // [R3]
		else $error("interrupt does not follow enable and full flag");
	full_set_a: assert property (frame_done |=> stat_r.rx_full_flag) // [R2]
		else $error("full flag missing after frame");
	frame_err_a: assert property (frame_done && !maj |=> stat_r.framing_error_flag) // [R11]
		else $error("zero stop bit did not set framing error");
	fe_with_full_a: assert property ($rose(stat_r.framing_error_flag) |-> $past(frame_done)) // [R13]
		else $error("framing error raised outside frame end");
	reject_search_a: assert property (start_reject |=> state_r == ST_SEARCH && rt_r == RT_IDLE) // [R8]
		else $error("rejected start did not restart search");
	reject_quiet_a: assert property (start_reject |=> !pend_r) // [R12]
		else $error("rejected start marked noise");
	pin_release_a: assert property (!tx_enable_bit && !tx_in_progress |-> !tx_pin_oe) // [R15]
		else $error("transmit pin still driven");
	break_clear_a: assert property (frame_done && brk |=> data_r == '0 && stat_r.framing_error_flag) // [R18]
		else $error("break did not clear data");
	ninth_mask_a: assert property (frame_done && !char_nine_bits |=> !data_r.rx_ninth_bit) // [R1]
		else $error("ninth bit set in 8-bit mode");
	edge_start_a: assert property (state_r == ST_SEARCH && rt_tick && edge_seen |=> state_r == ST_START && rt_r == RT_SECOND) // [R6]
		else $error("falling edge did not start verification");

	frame_c:  cover property (frame_done);
	break_c:  cover property (frame_done && brk);
	reject_c: cover property (start_reject);
	noise_c:  cover property ($rose(stat_r.noise_flag));
endmodule : asr_receiver
`default_nettype wire

// *** rtl/asr_pkg.sv ***
// shared constants and types for the asynchronous serial receiver
`default_nettype none
package asr_pkg;
	// ---------------------------------------------
	// divider and sample tick counter
	// ---------------------------------------------
	localparam int                DIV_W     = 13;            // divisor width, 16x tick divider
	localparam logic [DIV_W-1:0]  DIV_ONE   = 13'h0001;      // reload point of the divider
	localparam logic [DIV_W-1:0]  DIV_OFF   = 13'h0000;      // zero divisor stops the tick
	localparam int                RT_W      = 5;             // sample tick counter width
	localparam logic [RT_W-1:0]   RT_IDLE   = 5'h00;         // not inside a bit
	localparam logic [RT_W-1:0]   RT_FIRST  = 5'h01;         // first tick of a bit
	localparam logic [RT_W-1:0]   RT_SECOND = 5'h02;         // tick after a falling edge
	localparam logic [RT_W-1:0]   RT_V3     = 5'h03;         // start verify samples
	localparam logic [RT_W-1:0]   RT_V5     = 5'h05;
	localparam logic [RT_W-1:0]   RT_V7     = 5'h07;
	localparam logic [RT_W-1:0]   RT_M8     = 5'h08;         // majority samples
	localparam logic [RT_W-1:0]   RT_M9     = 5'h09;
	localparam logic [RT_W-1:0]   RT_M10    = 5'h0A;
	localparam logic [RT_W-1:0]   RT_LAST   = 5'h10;         // sixteenth tick ends the bit
	// ---------------------------------------------
	// character length and start detection
	// ---------------------------------------------
	localparam logic [3:0]        IDX_W8    = 4'h7;          // last data index, 8-bit characters
	localparam logic [3:0]        IDX_W9    = 4'h8;          // last data index, 9-bit characters
	localparam logic [2:0]        HIST_IDLE = 3'h7;          // three high samples before an edge
	localparam logic [1:0]        VOTE_REJ  = 2'h2;          // high verify samples that reject
	// ---------------------------------------------
	// carriers and states
	// ---------------------------------------------
	typedef struct packed {
		logic       rx_ninth_bit;                           // ninth bit in 9-bit mode
		logic [7:0] rx_low;                                 // low eight data bits
	} asr_data_t;
	typedef struct packed {
		logic rx_full_flag;                                 // character waiting
		logic noise_flag;                                   // samples disagreed
		logic framing_error_flag;                           // stop bit read as zero
	} asr_status_t;
	typedef enum logic [1:0] {ST_SEARCH, ST_START, ST_DATA, ST_STOP} asr_state_t;
endpackage : asr_pkg
`default_nettype wire

// *** verification/asr_tx_model.sv ***
// remote serial transmitter model that drives the receive line
`default_nettype none
module asr_tx_model (
	// clock
	input  wire logic                      mclk,
	// frame request, held steady while busy
	input  wire logic [asr_pkg::DIV_W-1:0] tick_cycles,
	input  wire logic                      go,
	input  wire logic [10:0]               frame,
	input  wire logic [3:0]                nbits,
	// one inverted burst: bit index and tick span
	input  wire logic [3:0]                gbit,
	input  wire logic [4:0]                gt0,
	input  wire logic [4:0]                gt1,
	// line and activity
	output wire logic                      line,
	output var  logic                      busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import asr_pkg::*;
	logic [DIV_W-1:0] cyc_r;                // mclk count inside a tick
	logic [4:0]       tk_r;                 // tick inside a bit, 1..16
	logic [3:0]       bit_r;                // bit index, start bit is 0
	// line idles high outside frames, burst inverts the bit
	assign line = !busy | (frame[bit_r] ^ (bit_r == gbit && tk_r >= gt0 && tk_r <= gt1));
	initial busy = 1'b0;
	// tick and bit counting
	always @(posedge mclk) begin
		if (!busy) begin
			busy  <= go;
			cyc_r <= DIV_OFF;
			tk_r  <= 5'h01;
			bit_r <= 4'h0;
		end else if (cyc_r != tick_cycles - DIV_ONE) begin
			cyc_r <= cyc_r + DIV_ONE;
		end else begin
			cyc_r <= DIV_OFF;
			tk_r  <= (tk_r == 5'h10) ? 5'h01 : tk_r + 5'h01;
			if (tk_r == 5'h10) begin
				bit_r <= bit_r + 4'h1;
				busy  <= (bit_r != nbits - 4'h1);
			end
		end
	end
endmodule : asr_tx_model
`default_nettype wire

// *** verification/asr_receiver_tb.sv ***
// self-checking bench for the serial receiver
`default_nettype none
module asr_receiver_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asr_pkg::*;
	localparam logic [DIV_W-1:0] TICKS = 13'h0004; // short ticks keep the run brief
	// one frame with its expected outcome
	typedef struct packed {
		logic        nine;
		logic [8:0]  dat;
		logic        stop;
		logic [3:0]  gb;
		logic [4:0]  g0;
		logic [4:0]  g1;
		asr_data_t   xd;
		asr_status_t xs;
	} asr_row_t;
	// gb 4'hF means no burst; status is {full, noise, framing}
	asr_row_t rows [8] = '{
		'{1'b0, 9'h0A5, 1'b1, 4'hF, 5'h00, 5'h00, 9'h0A5, 3'h4},
		'{1'b1, 9'h15A, 1'b1, 4'hF, 5'h00, 5'h00, 9'h15A, 3'h4},
		'{1'b0, 9'h03C, 1'b0, 4'hF, 5'h00, 5'h00, 9'h03C, 3'h5},
		'{1'b0, 9'h000, 1'b0, 4'hF, 5'h00, 5'h00, 9'h000, 3'h5},
		'{1'b1, 9'h000, 1'b0, 4'hF, 5'h00, 5'h00, 9'h000, 3'h5},
		'{1'b0, 9'h000, 1'b1, 4'h4, 5'h09, 5'h09, 9'h000, 3'h6},
		'{1'b0, 9'h081, 1'b1, 4'h0, 5'h04, 5'h05, 9'h081, 3'h6},
		'{1'b1, 9'h100, 1'b1, 4'h0, 5'h08, 5'h09, 9'h100, 3'h6}};
	logic        mclk   = 1'b0;     // system clock
	logic        rst_n  = 1'b0;     // reset, active low
	logic        nine   = 1'b0;     // nine-bit characters
	logic        irq_en = 1'b0;     // interrupt gate
	logic        rd     = 1'b0;     // read pulse
	logic        txe    = 1'b0;     // transmit enable
	logic        txp    = 1'b0;     // transmission in progress
	logic        go     = 1'b0;     // model frame request
	logic [10:0] frame  = 11'h7FF;  // bits on the wire, start first
	logic [3:0]  nbits  = 4'hA;     // bits in the frame
	logic [3:0]  gb     = 4'hF;     // burst bit index
	logic [4:0]  g0     = 5'h00;    // burst first tick
	logic [4:0]  g1     = 5'h00;    // burst last tick
	logic [DIV_W-1:0] bdiv = TICKS; // receiver tick divisor
	logic [DIV_W-1:0] mtk  = TICKS; // transmitter tick length, differs only for drift
	asr_data_t   rx_data;           // received character
	asr_status_t rx_status;         // sticky flags
	logic        rx_irq;            // interrupt request
	logic        oe;                // transmit pin owned
	logic        line;              // serial line
	logic        busy;              // model sending
	int          err_count    = 0;
	int          total_checks = 0;
	always #5 mclk = ~mclk;
	asr_receiver i_dut (
		.mclk(mclk), .rst_n(rst_n), .rx_pin(line), .char_nine_bits(nine), .rx_irq_enable(irq_en),
		.baud_div(bdiv), .rx_read(rd), .rx_data(rx_data), .rx_status(rx_status), .rx_irq(rx_irq),
		.tx_enable_bit(txe), .tx_in_progress(txp), .tx_pin_oe(oe));
	asr_tx_model i_tx (
		.mclk(mclk), .tick_cycles(mtk), .go(go), .frame(frame), .nbits(nbits), .gbit(gb),
		.gt0(g0), .gt1(g1), .line(line), .busy(busy));
	// compare and count
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// one frame, bounded wait, then idle gap
	task automatic send(input logic nb, input logic [8:0] d, input logic st, input logic [3:0] b,
		input logic [4:0] t0, input logic [4:0] t1);
		int n;
		n = 0;
		nine  <= nb;
		frame <= nb ? {st, d, 1'b0} : {1'b1, st, d[7:0], 1'b0};
		nbits <= nb ? 4'hB : 4'hA;
		gb    <= b;
		g0    <= t0;
		g1    <= t1;
		go    <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (2) @(posedge mclk);
		while (busy && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		if (busy) begin
			err_count++;
			print_verdict();
		end
		repeat (6 * TICKS) @(posedge mclk);
	endtask : send
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		foreach (rows[i]) begin
			irq_en <= i[0];
			send(rows[i].nine, rows[i].dat, rows[i].stop, rows[i].gb, rows[i].g0, rows[i].g1);
			chk(rx_data, rows[i].xd); // data and break
			chk({6'h00, rx_status}, {6'h00, rows[i].xs}); // flags
			chk({8'h00, rx_irq}, {8'h00, i[0] & rows[i].xs.rx_full_flag}); // request
			rd <= 1'b1;
			@(posedge mclk);
			rd <= 1'b0;
			@(posedge mclk);
			chk({6'h00, rx_status}, 9'h000); // flags cleared
			$display("row %0d done", i);
		end
		// short low: verify samples high, so no start and no noise
		send(1'b0, 9'h0FF, 1'b1, 4'h0, 5'h03, 5'h10);
		chk({6'h00, rx_status}, 9'h000); // rejected start
		$display("rejected start done");
		// noise stays sticky while a clean frame overwrites the data
		send(1'b0, 9'h000, 1'b1, 4'h4, 5'h09, 5'h09);
		send(1'b0, 9'h055, 1'b1, 4'hF, 5'h00, 5'h00);
		chk(rx_data, 9'h055); // overwrite
		chk({6'h00, rx_status}, 9'h006); // sticky noise
		$display("accumulate done");
		// transmitter an eighth fast, then an eighth slow: only edge resync keeps 0x55 intact
		for (int k = 0; k < 2; k++) begin
			rd   <= 1'b1;
			bdiv <= 13'h0008;
			mtk  <= k[0] ? 13'h0009 : 13'h0007;
			@(posedge mclk);
			rd <= 1'b0;
			send(1'b0, 9'h055, 1'b1, 4'hF, 5'h00, 5'h00);
			chk(rx_data, 9'h055); // drift corrected
			chk({6'h00, rx_status}, 9'h004); // clean stop, no noise
		end
		bdiv <= TICKS;
		mtk  <= TICKS;
		$display("drift done");
		// pin ownership while enable toggles
		for (int k = 0; k < 4; k++) begin
			txe <= k[0];
			txp <= k[1];
			@(posedge mclk);
			@(posedge mclk);
			chk({8'h00, oe}, {8'h00, k[0] | k[1]}); // pin release
		end
		$display("pin ownership done");
		// reset in mid-run clears data and flags
		rst_n <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		chk(rx_data, 9'h000); // reset data
		chk({6'h00, rx_status}, 9'h000); // reset flags
		$display("reset done");
		// second release: the receiver must take a frame again
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		send(1'b1, 9'h1C3, 1'b1, 4'hF, 5'h00, 5'h00);
		chk(rx_data, 9'h1C3); // frame after release
		chk({6'h00, rx_status}, 9'h004); // full flag only
		chk({8'h00, rx_irq}, 9'h001); // enabled request
		$display("release done");
		print_verdict();
	end
endmodule : asr_receiver_tb
`default_nettype wire
